/* common/link_regs_map.svh */
// Purpose: offsets, field positions and reset values of the link control/status pair
// Assumes: config space addressed by byte offset, 16-bit register access
// Notes: definitions only
`ifndef LINK_REGS_MAP_SVH
`define LINK_REGS_MAP_SVH
`define LINK_CTRL_OFS 8'hB0
`define LINK_STAT_OFS 8'hB2
`define CTRL_ASPM_LO 0
`define CTRL_ASPM_HI 1
`define CTRL_RCB 3
`define CTRL_CCLK 6
`define CTRL_XSYNC 7
`define ASPM_RST 2'h0
`define RCB_RST 1'h0
`define CCLK_RST 1'h0
`define XSYNC_RST 1'h0
`define STAT_SPEED_2G5 4'h1
`define STAT_WIDTH_X1 6'h01
`define SLOT_CLK_RST 1'h1
`define NVM_WORD_L0S_LAT 8'h18
`define NVM_WORD_SLOT_CFG 8'h1A
`define NVM_SLOT_CLK_BIT 12
`define NVM_LAT_SEP_LO 0
`define NVM_LAT_COM_LO 3
`define LAT_W 3
`define STAT_SPEED_LO 0
`define STAT_SPEED_HI 3
`define STAT_WIDTH_LO 4
`define STAT_WIDTH_HI 9
`define STAT_TRAIN_BIT 11
`define STAT_SLOT_BIT 12
`define NVM_LAT_FIELD_LO 0
`define NVM_LAT_FIELD_HI 5
`define REG_ZERO 16'h0000
`define NVM_LAT_RST 6'h00
`define LAT_SEL_RST 3'h0
`define TRAIN_RST 1'h0
`define EN_RST 1'h0
`define RX_L0S_ON 1'h1
`endif

/* common/link_regs_pkg.sv */
// Purpose: shared types for the link register bank
// Assumes: nothing beyond the map header
// Notes: aspm codes as seen in link control
package link_regs_pkg;
	typedef enum logic [1:0] {ASPM_OFF, ASPM_L0S, ASPM_L1, ASPM_BOTH} aspm_e;
	typedef logic [15:0] reg16_t;
endpackage

/* common/nvm_if.sv */
// Purpose: carries words loaded from the integrated nonvolatile store
// Assumes: loader presents word address and data with a strobe
// Notes: capture side is the modport cap
`timescale 1ns/1ns
`default_nettype none
interface nvm_if;
	logic load;
	logic [7:0] addr;
	logic [15:0] data;
	logic slot_clk;
	logic [5:0] l0s_lat;
	modport src(output load, output addr, output data, input slot_clk, input l0s_lat);
	modport cap(input load, input addr, input data, output slot_clk, output l0s_lat);
endinterface
`default_nettype wire

/* rtl/link_ctrl_status.sv */
// Contract
// - two-bit writable aspm control field
// - receiver may enter l0s regardless
// - function reset keeps aspm, clock, synch
// - rcb bit: 0=64B, 1=128B, resets zero
// - link disable, retrain hardwired zero
// - common clock bit selects l0s latency
// - extended synch lengthens l0s exit; here only passed out on ext_synch, l0s_exit_lat does not depend on it
// - unsupported and reserved control bits read zero
// - speed reports 2.5 Gb/s code
// - width reports single lane
// - training bit follows link training
// - slot clock loaded from store, default one
// - unsupported status bits read zero
// - l0s latency from store by clock mode
// Purpose: link control and link status capability registers of an x1 endpoint
// Assumes: config accesses are 16-bit, one-cycle strobes on clk; training flag synchronous
// Notes: read data registered one cycle after rd_en
`timescale 1ns/1ns
`default_nettype none
`include "link_regs_map.svh"
module link_ctrl_status
	import link_regs_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic flr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [15:0] wr_data,
	input wire logic [1:0] wr_be,
	input wire logic training,
	input wire logic nvm_load,
	input wire logic [7:0] nvm_addr,
	input wire logic [15:0] nvm_data,
	output logic [15:0] rd_data,
	output logic aspm_tx_l0s_en,
	output logic aspm_l1_en,
	output logic rx_l0s_en,
	output logic rcb_128,
	output logic ext_synch,
	output logic [2:0] l0s_exit_lat
);
	nvm_if nvm();
	aspm_e aspm_r;
	aspm_e aspm_nxt;
	logic rcb_r;
	logic rcb_nxt;
	logic cclk_r;
	logic cclk_nxt;
	logic xsync_r;
	logic xsync_nxt;
	logic train_r;
	logic train_nxt;
	reg16_t rd_r;
	reg16_t rd_nxt;
	logic [2:0] lat_r;
	logic [2:0] lat_nxt;
	logic tx_l0s_r;
	logic tx_l0s_nxt;
	logic l1_r;
	logic l1_nxt;
	logic rx_l0s_r;
	logic rx_l0s_nxt;

	assign nvm.load = nvm_load;
	assign nvm.addr = nvm_addr;
	assign nvm.data = nvm_data;

	nvm_capture u_nvm (
		.clk(clk),
		.srst(srst),
		.nvm(nvm)
	);

	function automatic reg16_t ctrl_view(aspm_e a, logic r, logic c, logic x);
		reg16_t v;
		v = `REG_ZERO;
		v[`CTRL_ASPM_HI:`CTRL_ASPM_LO] = a;
		v[`CTRL_RCB] = r;
		v[`CTRL_CCLK] = c;
		v[`CTRL_XSYNC] = x;
		return v;
	endfunction

	function automatic reg16_t stat_view(logic t, logic s);
		reg16_t v;
		v = `REG_ZERO;
		v[`STAT_SPEED_HI:`STAT_SPEED_LO] = `STAT_SPEED_2G5;
		v[`STAT_WIDTH_HI:`STAT_WIDTH_LO] = `STAT_WIDTH_X1;
		v[`STAT_TRAIN_BIT] = t;
		v[`STAT_SLOT_BIT] = s;
		return v;
	endfunction

	// register select, shared by write and read paths
	function automatic logic addr_hit(logic [7:0] a, logic [7:0] ofs);
		return a == ofs;
	endfunction

	// transmitter l0s allowed for codes 01b and 11b
	function automatic logic aspm_l0s_ok(aspm_e a);
		return a == ASPM_L0S || a == ASPM_BOTH;
	endfunction

	// l1 allowed for codes 10b and 11b
	function automatic logic aspm_l1_ok(aspm_e a);
		return a == ASPM_L1 || a == ASPM_BOTH;
	endfunction

	// control register writes
	always_comb
	begin
		aspm_nxt = aspm_r;
		rcb_nxt = rcb_r;
		cclk_nxt = cclk_r;
		xsync_nxt = xsync_r;
		if (wr_en && addr_hit(addr, `LINK_CTRL_OFS) && wr_be[0])
		begin
			aspm_nxt = aspm_e'(wr_data[`CTRL_ASPM_HI:`CTRL_ASPM_LO]);
			rcb_nxt = wr_data[`CTRL_RCB];
			cclk_nxt = wr_data[`CTRL_CCLK];
			xsync_nxt = wr_data[`CTRL_XSYNC];
		end
		if (flr)
			rcb_nxt = `RCB_RST;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			aspm_r <= aspm_e'(`ASPM_RST);
			rcb_r <= `RCB_RST;
			cclk_r <= `CCLK_RST;
			xsync_r <= `XSYNC_RST;
		end
		else
		begin
			aspm_r <= aspm_nxt;
			rcb_r <= rcb_nxt;
			cclk_r <= cclk_nxt;
			xsync_r <= xsync_nxt;
		end
	end

	// read path and training flag
	always_comb
	begin
		rd_nxt = `REG_ZERO;
		if (rd_en && addr_hit(addr, `LINK_CTRL_OFS))
			rd_nxt = ctrl_view(aspm_r, rcb_r, cclk_r, xsync_r);
		else if (rd_en && addr_hit(addr, `LINK_STAT_OFS))
			rd_nxt = stat_view(train_r, nvm.slot_clk);
		train_nxt = training;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rd_r <= `REG_ZERO;
			train_r <= `TRAIN_RST;
		end
		else
		begin
			rd_r <= rd_nxt;
			train_r <= train_nxt;
		end
	end

	// l0s exit latency follows the common clock bit
	always_comb
	begin
		if (cclk_r)
			lat_nxt = nvm.l0s_lat[`NVM_LAT_COM_LO +: `LAT_W];
		else
			lat_nxt = nvm.l0s_lat[`NVM_LAT_SEP_LO +: `LAT_W];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			lat_r <= `LAT_SEL_RST;
		else
			lat_r <= lat_nxt;
	end

	// power enables; receiver l0s never gated by the aspm code
	always_comb
	begin
		tx_l0s_nxt = aspm_l0s_ok(aspm_r);
		l1_nxt = aspm_l1_ok(aspm_r);
		rx_l0s_nxt = `RX_L0S_ON;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tx_l0s_r <= `EN_RST;
			l1_r <= `EN_RST;
			rx_l0s_r <= `RX_L0S_ON;
		end
		else
		begin
			tx_l0s_r <= tx_l0s_nxt;
			l1_r <= l1_nxt;
			rx_l0s_r <= rx_l0s_nxt;
		end
	end

	assign rd_data = rd_r;
	assign aspm_tx_l0s_en = tx_l0s_r;
	assign aspm_l1_en = l1_r;
	assign rx_l0s_en = rx_l0s_r;
	assign rcb_128 = rcb_r;
	assign ext_synch = xsync_r;
	assign l0s_exit_lat = lat_r;
endmodule
`default_nettype wire

/* rtl/nvm_capture.sv */
// Purpose: keeps the init-time values taken from the integrated nonvolatile store
// Assumes: load strobes come from logic on clk
// Notes: values held in registers
`timescale 1ns/1ns
`default_nettype none
`include "link_regs_map.svh"
module nvm_capture
	import link_regs_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	nvm_if.cap nvm
);
	logic slot_r;
	logic slot_nxt;
	logic [5:0] lat_r;
	logic [5:0] lat_nxt;

	always_comb
	begin
		slot_nxt = slot_r;
		lat_nxt = lat_r;
		if (nvm.load && nvm.addr == `NVM_WORD_SLOT_CFG)
			slot_nxt = nvm.data[`NVM_SLOT_CLK_BIT];
		if (nvm.load && nvm.addr == `NVM_WORD_L0S_LAT)
			lat_nxt = nvm.data[`NVM_LAT_FIELD_HI:`NVM_LAT_FIELD_LO];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			slot_r <= `SLOT_CLK_RST;
			lat_r <= `NVM_LAT_RST;
		end
		else
		begin
			slot_r <= slot_nxt;
			lat_r <= lat_nxt;
		end
	end

	assign nvm.slot_clk = slot_r;
	assign nvm.l0s_lat = lat_r;
endmodule
`default_nettype wire

/* verification/link_ctrl_status_monitor.sv */
// Purpose: port checks
// Assumes: top ports only
// Notes: bound below
`timescale 1ns/1ns
`default_nettype none
module link_ctrl_status_monitor (
	input wire logic clk,
	input wire logic srst,
	input wire logic flr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [15:0] wr_data,
	input wire logic [1:0] wr_be,
	input wire logic training,
	input wire logic [15:0] rd_data,
	input wire logic aspm_tx_l0s_en,
	input wire logic aspm_l1_en,
	input wire logic rx_l0s_en,
	input wire logic rcb_128,
	input wire logic ext_synch
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	logic cw;
	logic rs;
	assign cw = wr_en && addr == 8'hB0 && wr_be[0];
	assign rs = rd_en && addr == 8'hB2;
	rx_l0s_a: assert property (rx_l0s_en) else $error("rx l0s");
	rcb_wr_a: assert property (cw && !flr |=> rcb_128 == $past(wr_data[3])) else $error("rcb");
	synch_wr_a: assert property (cw |=> ext_synch == $past(wr_data[7])) else $error("synch");
	aspm_wr_a: assert property (cw ##1 !wr_en |=> {aspm_l1_en, aspm_tx_l0s_en} == $past(wr_data[1:0], 2))
		else $error("aspm");
	flr_keep_a: assert property (flr && !cw && !$past(cw) |=> $stable(ext_synch) && !rcb_128)
		else $error("flr");
	aspm_flr_a: assert property (flr && !cw |=> ##1 $stable({aspm_l1_en, aspm_tx_l0s_en}))
		else $error("aspm kept");
	stat_ro_a: assert property (rs |=> (rd_data & 16'hE7FF) == 16'h0011) else $error("status");
	train_rd_a: assert property (rs |=> rd_data[11] == $past(training, 2)) else $error("train");
	ctl_rd_a: assert property (rd_en && addr == 8'hB0 |=> (rd_data & 16'hFF34) == 16'h0
		&& rd_data[3] == $past(rcb_128) && rd_data[7] == $past(ext_synch)) else $error("ctl");
endmodule
bind link_ctrl_status link_ctrl_status_monitor u_link_ctrl_status_monitor (.clk(clk), .srst(srst), .flr(flr),
	.wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .wr_be(wr_be), .training(training),
	.rd_data(rd_data), .aspm_tx_l0s_en(aspm_tx_l0s_en), .aspm_l1_en(aspm_l1_en), .rx_l0s_en(rx_l0s_en),
	.rcb_128(rcb_128), .ext_synch(ext_synch));
`default_nettype wire

/* verification/link_ctrl_status_test.sv */
// Purpose: bench for link_ctrl_status
// Assumes: store loaded by model
// Notes: fixed seed
`timescale 1ns/1ns
`default_nettype none
module link_ctrl_status_test;
	logic clk = 0, srst = 1, flr = 0, wr_en = 0, rd_en = 0, training = 0, go = 0;
	logic [7:0] addr = 0, nvm_addr;
	logic [15:0] wr_data = 0, nvm_data, rd_data, lat_w = 0, d;
	logic [1:0] wr_be = 2'h1;
	logic nvm_load, aspm_tx_l0s_en, aspm_l1_en, rx_l0s_en, rcb_128, ext_synch;
	logic [2:0] l0s_exit_lat;
	logic [31:0] seed = 32'h9F73;
	int num_errors = 0, checks_done = 0;
	always #5 clk = ~clk;
	link_ctrl_status u_link_ctrl_status (.clk(clk), .srst(srst), .flr(flr), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wr_data(wr_data), .wr_be(wr_be), .training(training), .nvm_load(nvm_load), .nvm_addr(nvm_addr),
		.nvm_data(nvm_data), .rd_data(rd_data), .aspm_tx_l0s_en(aspm_tx_l0s_en), .aspm_l1_en(aspm_l1_en),
		.rx_l0s_en(rx_l0s_en), .rcb_128(rcb_128), .ext_synch(ext_synch), .l0s_exit_lat(l0s_exit_lat));
	nvm_store_model u_nvm_store_model (.clk(clk), .go(go), .lat_w(lat_w), .slot_w(16'h0), .load(nvm_load),
		.addr(nvm_addr), .data(nvm_data));
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic acc(logic w, logic [7:0] a, logic [15:0] e);
		@(posedge clk) #1;
		wr_en = w;
		rd_en = !w;
		addr = a;
		wr_data = e;
		@(posedge clk) #1;
		wr_en = 0;
		rd_en = 0;
		if (!w)
			chk(rd_data, e);
	endtask
	task automatic print_verdict();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#100000;
		num_errors++;
		print_verdict();
	end
	initial
	begin
		repeat (16) @(posedge clk);
		#1 srst = 0;
		acc(0, 8'hB2, 16'h1011);
		lat_w = seed[15:0];
		go = 1;
		@(posedge clk) #1 go = 0;
		repeat (2) @(posedge clk);
		acc(0, 8'hB2, 16'h0011);
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			d = {seed[15:2], i[1:0]};
			acc(1, 8'hB0, d);
			training = seed[20];
			@(posedge clk) #1;
			chk({rx_l0s_en, aspm_l1_en, aspm_tx_l0s_en}, {1'b1, i[1:0]});
			chk({ext_synch, rcb_128}, {d[7], d[3]});
			chk(l0s_exit_lat, d[6] ? lat_w[5:3] : lat_w[2:0]);
			acc(0, 8'hB0, d & 16'h00CB);
			acc(0, 8'hB2, {4'h0, training, 11'h011});
		end
		acc(1, 8'hB2, 16'hFFFF);
		acc(0, 8'hB0, d & 16'h00CB);
		acc(0, 8'hB2, {4'h0, training, 11'h011});
		wr_be = 2'h2;
		acc(1, 8'hB0, 16'hFFFF);
		wr_be = 2'h1;
		acc(0, 8'hB0, d & 16'h00CB);
		acc(1, 8'hB0, 16'h00CB);
		@(posedge clk) #1 flr = 1;
		@(posedge clk) #1 flr = 0;
		acc(0, 8'hB0, 16'h00C3);
		training = 0;
		srst = 1;
		repeat (2) @(posedge clk);
		#1 srst = 0;
		acc(0, 8'hB0, 16'h0000);
		acc(0, 8'hB2, 16'h1011);
		chk({aspm_l1_en, aspm_tx_l0s_en, rcb_128, ext_synch, l0s_exit_lat}, 16'h0000);
		print_verdict();
	end
endmodule
`default_nettype wire

/* verification/nvm_store_model.sv */
// Purpose: store loader model
// Assumes: go is a pulse
// Notes: data scrambled when idle
`timescale 1ns/1ns
`default_nettype none
module nvm_store_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [15:0] lat_w,
	input wire logic [15:0] slot_w,
	output logic load,
	output logic [7:0] addr,
	output logic [15:0] data
);
	logic ph_r = 1'b0;
	logic load_r = 1'b0;
	logic [7:0] addr_r = 8'h00;
	logic [15:0] data_r = 16'h0000;
	always @(posedge clk)
	begin
		load_r <= go | ph_r;
		ph_r <= go;
		addr_r <= ph_r ? 8'h1A : 8'h18;
		data_r <= go ? lat_w : ph_r ? slot_w : ~data_r;
	end
	assign load = load_r;
	assign addr = addr_r;
	assign data = data_r;
endmodule
`default_nettype wire
